// >>> src/bcs_pkg.sv
// package with register map, field layout and types for the bridge channel scan control
// Notes on behaviour
// - excitation code: 1023 equal steps, 0 to 5 V
// - one excitation code per six-channel bank
// - offset code 0..4095 per channel, 2048 mid
// - multiplexed only: one channel onto one output
// - scan sequence kept in a loaded list, read from entry zero and wrapping after the last
// - channels visited in exact list order
// - repeated channels in a list all visited
// - scanned, not cabled: drive shared backplane bus
// - scanned and cabled: drive input line zero
// - control logic opens and closes shunt switch
package bcs_pkg;
	// geometry
	localparam int CHANNELS   = 24;
	localparam int BANKS      = 4;
	localparam int CH_W       = 5;
	localparam int EXC_W      = 10;
	localparam int OFS_W      = 12;
	localparam int LIST_DEPTH = 512;
	localparam int IDX_W      = 9;
	localparam int CNT_W      = 10;

	// reset values and highest channel number
	localparam logic [EXC_W-1:0] EXC_RESET = 10'h000;
	localparam logic [OFS_W-1:0] OFS_MID   = 12'h800;
	localparam logic [CH_W-1:0]  CH_LAST   = 5'h17;

	// register byte addresses
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_STATUS  = 12'h004;
	localparam logic [11:0] ADDR_LIST    = 12'h008;
	localparam logic [11:0] ADDR_TRIGGER = 12'h00C;
	localparam logic [11:0] ADDR_EXC     = 12'h010;
	localparam logic [11:0] ADDR_OFS     = 12'h040;
	localparam logic [11:0] ADDR_OFS_END = 12'h09C;

	// control field positions
	localparam int CTRL_SCAN   = 0;
	localparam int CTRL_CABLED = 1;
	localparam int CTRL_SHUNT  = 2;
	localparam int CTRL_CLEAR  = 3;

	// status field positions
	localparam int ST_SEL   = 0;
	localparam int ST_IDX   = 5;
	localparam int ST_CNT   = 14;
	localparam int ST_SCAN  = 24;
	localparam int ST_ERROR = 25;

	typedef logic [BANKS-1:0][EXC_W-1:0]    bcs_exc_t;
	typedef logic [CHANNELS-1:0][OFS_W-1:0] bcs_ofs_t;

	// output routing of the selected channel
	typedef struct packed {
		logic backplane_drive;
		logic line_zero_own;
		logic line_zero_forward;
	} bcs_route_s;

	typedef enum logic [1:0] {
		ST_IDLE_SCAN = 2'b01,
		ST_RUN_SCAN  = 2'b10
	} bcs_state_e;
endpackage

// >>> src/bcs_bridge_channel_scan_control.sv
// top module: apb registers, scan list and output multiplexer control
`timescale 1ns/1ps
`default_nettype none
module bcs_bridge_channel_scan_control (
	// clock and reset
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	// apb slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// scan timing from digitizer and chassis
	input  wire logic                   conv_trigger,
	input  wire logic                   module_scanned,
	// analog control
	output logic      [4:0]             mux_select,
	output bcs_pkg::bcs_route_s         route,
	output logic                        shunt_closed,
	output bcs_pkg::bcs_exc_t           exc_code,
	output bcs_pkg::bcs_ofs_t           ofs_code
);
	logic [bcs_pkg::CH_W-1:0]  scan_list [bcs_pkg::LIST_DEPTH];
	logic [bcs_pkg::CNT_W-1:0] list_count;
	logic [bcs_pkg::IDX_W-1:0] list_idx;
	logic [bcs_pkg::IDX_W-1:0] next_idx;
	logic                      scan_en;
	logic                      cabled;
	logic                      list_error;
	bcs_pkg::bcs_state_e       state;
	logic                      setup;
	logic                      wr_acc;
	logic                      list_push;
	logic                      list_clear;
	logic                      advance;
	logic                      start;

	// byte address inside the offset block
	function automatic logic is_ofs(input logic [11:0] a);
		return a >= bcs_pkg::ADDR_OFS && a <= bcs_pkg::ADDR_OFS_END && a[1:0] == 2'b00;
	endfunction

	// channel number of an offset register
	function automatic logic [4:0] ofs_index(input logic [11:0] a);
		logic [11:0] d;
		d = a - bcs_pkg::ADDR_OFS;
		return d[6:2];
	endfunction

	// excitation bank addresses
	function automatic logic is_exc(input logic [11:0] a);
		return a[11:4] == bcs_pkg::ADDR_EXC[11:4] && a[1:0] == 2'b00;
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		return a == bcs_pkg::ADDR_CTRL || a == bcs_pkg::ADDR_STATUS
			|| a == bcs_pkg::ADDR_LIST || a == bcs_pkg::ADDR_TRIGGER
			|| is_exc(a) || is_ofs(a);
	endfunction

	// bus phase decode
	assign setup      = psel && !penable;
	assign wr_acc     = psel && penable && pready && pwrite && is_mapped(paddr);
	assign list_clear = wr_acc && paddr == bcs_pkg::ADDR_CTRL && pwdata[bcs_pkg::CTRL_CLEAR];
	// list is frozen while scanning so the sequence stays consistent
	assign list_push  = wr_acc && paddr == bcs_pkg::ADDR_LIST && state == bcs_pkg::ST_IDLE_SCAN;
	assign start      = state == bcs_pkg::ST_IDLE_SCAN && scan_en && list_count != '0;
	assign advance    = state == bcs_pkg::ST_RUN_SCAN && (conv_trigger
		|| (wr_acc && paddr == bcs_pkg::ADDR_TRIGGER));

	// wrap after the last loaded entry
	always_comb begin
		if ({1'b0, list_idx} + 10'h001 >= list_count) begin
			next_idx = '0;
		end else begin
			next_idx = list_idx + 9'h001;
		end
	end

	// apb answers with no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
		end
	end

	// read data and error captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			pslverr <= !is_mapped(paddr);
			prdata  <= 32'h0000_0000;
			if (!pwrite) begin
				if (paddr == bcs_pkg::ADDR_CTRL) begin
					prdata[bcs_pkg::CTRL_SCAN]   <= scan_en;
					prdata[bcs_pkg::CTRL_CABLED] <= cabled;
					prdata[bcs_pkg::CTRL_SHUNT]  <= shunt_closed;
				end else if (paddr == bcs_pkg::ADDR_STATUS) begin
					prdata[bcs_pkg::ST_SEL +: bcs_pkg::CH_W]  <= mux_select;
					prdata[bcs_pkg::ST_IDX +: bcs_pkg::IDX_W] <= list_idx;
					prdata[bcs_pkg::ST_CNT +: bcs_pkg::CNT_W] <= list_count;
					prdata[bcs_pkg::ST_SCAN]  <= state == bcs_pkg::ST_RUN_SCAN;
					prdata[bcs_pkg::ST_ERROR] <= list_error;
				end else if (is_exc(paddr)) begin
					prdata[bcs_pkg::EXC_W-1:0] <= exc_code[paddr[3:2]];
				end else if (is_ofs(paddr)) begin
					prdata[bcs_pkg::OFS_W-1:0] <= ofs_code[ofs_index(paddr)];
				end
			end
		end
	end

	// control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_en      <= 1'b0;
			cabled       <= 1'b0;
			shunt_closed <= 1'b0;
		end else if (wr_acc && paddr == bcs_pkg::ADDR_CTRL) begin
			scan_en      <= pwdata[bcs_pkg::CTRL_SCAN];
			cabled       <= pwdata[bcs_pkg::CTRL_CABLED];
			shunt_closed <= pwdata[bcs_pkg::CTRL_SHUNT];
		end
	end

	// excitation code per bank of six channels, 1023 steps up to full scale
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc_code <= {bcs_pkg::BANKS{bcs_pkg::EXC_RESET}};
		end else if (wr_acc && is_exc(paddr)) begin
			exc_code[paddr[3:2]] <= pwdata[bcs_pkg::EXC_W-1:0];
		end
	end

	// offset null code per channel, reset to mid-scale for no correction
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ofs_code <= {bcs_pkg::CHANNELS{bcs_pkg::OFS_MID}};
		end else if (wr_acc && is_ofs(paddr)) begin
			ofs_code[ofs_index(paddr)] <= pwdata[bcs_pkg::OFS_W-1:0];
		end
	end

	// scan list storage; entries stay until cleared, repeats allowed
	always_ff @(posedge pclk) begin
		if (list_push && list_count < bcs_pkg::CNT_W'(bcs_pkg::LIST_DEPTH)
			&& pwdata[bcs_pkg::CH_W-1:0] <= bcs_pkg::CH_LAST) begin
			scan_list[list_count[bcs_pkg::IDX_W-1:0]] <= pwdata[bcs_pkg::CH_W-1:0];
		end
	end

	// fill level and sticky error for a full list or a bad channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			list_count <= '0;
			list_error <= 1'b0;
		end else if (list_clear && state == bcs_pkg::ST_IDLE_SCAN) begin
			list_count <= '0;
			list_error <= 1'b0;
		end else if (list_push) begin
			// depth caps what one module can hold; the system total is the loader's job
			if (list_count >= bcs_pkg::CNT_W'(bcs_pkg::LIST_DEPTH)
				|| pwdata[bcs_pkg::CH_W-1:0] > bcs_pkg::CH_LAST) begin
				list_error <= 1'b1;
			end else begin
				list_count <= list_count + 10'h001;
			end
		end
	end

	// scan sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= bcs_pkg::ST_IDLE_SCAN;
			list_idx <= '0;
		end else begin
			case (state)
				bcs_pkg::ST_IDLE_SCAN: begin
					list_idx <= '0;
					if (start) begin
						state <= bcs_pkg::ST_RUN_SCAN;
					end
				end
				bcs_pkg::ST_RUN_SCAN: begin
					if (!scan_en) begin
						state <= bcs_pkg::ST_IDLE_SCAN;
					end else if (advance) begin
						list_idx <= next_idx;
					end
				end
				default: begin
					state <= bcs_pkg::ST_IDLE_SCAN;
				end
			endcase
		end
	end

	// single multiplexer selection, taken straight from the list entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mux_select <= 5'h00;
		end else if (start) begin
			mux_select <= scan_list[0];
		end else if (advance && scan_en) begin
			mux_select <= scan_list[next_idx];
		end
	end

	// output routing; the chassis decides when this module is scanned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route <= '0;
		end else begin
			route.backplane_drive   <= state == bcs_pkg::ST_RUN_SCAN && module_scanned
				&& !cabled;
			route.line_zero_own     <= state == bcs_pkg::ST_RUN_SCAN && module_scanned
				&& cabled;
			// forwarding relies on the chassis sequence chosen before the scan
			route.line_zero_forward <= cabled && !module_scanned;
		end
	end
endmodule
`default_nettype wire

// >>> bench/bcs_chk.sv
// port checker for the scan control block
`timescale 1ns/1ps
`default_nettype none
module bcs_chk (
	// clock, reset, apb
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// scan and analog control
	input wire logic                conv_trigger,
	input wire logic                module_scanned,
	input wire logic [4:0]          mux_select,
	input wire bcs_pkg::bcs_route_s route,
	input wire bcs_pkg::bcs_exc_t   exc_code,
	input wire bcs_pkg::bcs_ofs_t   ofs_code
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	// completed write
	assign wr = psel && penable && pwrite;
	AST_READY: assert property (presetn && $past(presetn) |-> pready)
		else $error("pready low after reset");
	AST_EXC_HOLD: assert property (!wr |=> $stable(exc_code))
		else $error("excitation moved without write");
	AST_OFS_HOLD: assert property (!wr |=> $stable(ofs_code))
		else $error("offset moved without write");
	AST_EXC_WR: assert property (wr && paddr == 12'h018 |=> exc_code[2] == $past(pwdata[9:0]))
		else $error("bank two code not taken");
	AST_OFS_WR: assert property (wr && paddr == 12'h054 |=> ofs_code[5] == $past(pwdata[11:0]))
		else $error("channel five offset not taken");
	AST_SLVERR: assert property (psel && !penable && paddr == 12'h0FC |=> pslverr)
		else $error("unmapped access not flagged");
	AST_ROUTE: assert property (route.backplane_drive || route.line_zero_own |-> $past(module_scanned))
		else $error("output driven while not scanned");
	AST_MUX: assert property ($changed(mux_select) |-> $past(conv_trigger) || $past(penable) || $past(penable, 2))
		else $error("channel moved without trigger");
endmodule
bind bcs_bridge_channel_scan_control bcs_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .conv_trigger, .module_scanned, .mux_select, .route,
	.exc_code, .ofs_code);
`default_nettype wire

// >>> bench/bcs_far_model.sv
// digitizer trigger and chassis module select
`timescale 1ns/1ps
`default_nettype none
module bcs_far_model (
	// clock
	input  wire logic pclk,
	// scan timing toward the module
	output var logic  conv_trigger,
	output var logic  module_scanned
);
	initial begin
		conv_trigger = 1'b0;
		module_scanned = 1'b0;
	end
	// chassis picks the driving module ahead of the scan
	task automatic select(input logic s);
		@(posedge pclk);
		module_scanned <= s;
	endtask
	// one conversion strobe; gap sets the pace
	task automatic convert(input int gap);
		@(posedge pclk);
		conv_trigger <= 1'b1;
		@(posedge pclk);
		conv_trigger <= 1'b0;
		repeat (gap) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

// >>> bench/bcs_bridge_channel_scan_control_tb_top.sv
// self-checking bench for the scan control block
`timescale 1ns/1ps
`default_nettype none
module bcs_bridge_channel_scan_control_tb_top;
	logic                pclk;
	logic                presetn;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [11:0]         paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                trig;
	logic                scanned;
	logic [4:0]          mux;
	bcs_pkg::bcs_route_s route;
	logic                shunt;
	bcs_pkg::bcs_exc_t   exc;
	bcs_pkg::bcs_ofs_t   ofs;
	logic [31:0]         rd;
	logic                err;
	int                  n_fail = 0;
	int                  compares = 0;

	bcs_bridge_channel_scan_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .conv_trigger(trig), .module_scanned(scanned),
		.mux_select(mux), .route, .shunt_closed(shunt), .exc_code(exc), .ofs_code(ofs));
	bcs_far_model far_u (.pclk, .conv_trigger(trig), .module_scanned(scanned));

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// idle edge before setup so psel never toggles twice in one step
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic t_reset;
		for (int b = 0; b < 4; b++) chk("exc", 32'(exc[b]), 32'h0000_0000);
		for (int c = 0; c < 24; c++) chk("ofs", 32'(ofs[c]), 32'h0000_0800);
	endtask
	// full-scale bank code and both ends of the offset range
	task automatic t_codes;
		apb(1'b1, 12'h018, 32'h0000_03FF);
		apb(1'b1, 12'h054, 32'h0000_0FFF);
		apb(1'b1, 12'h058, 32'h0000_0000);
		apb(1'b0, 12'h018, 32'h0000_0000);
		chk("exc2", 32'(exc[2]), 32'h0000_03FF);
		chk("exc1", 32'(exc[1]), 32'h0000_0000);
		chk("ofs5", 32'(ofs[5]), 32'h0000_0FFF);
		chk("ofs6", 32'(ofs[6]), 32'h0000_0000);
		chk("exc2 rd", rd, 32'h0000_03FF);
	endtask
	// repeat and ascending step in the list, then wrap
	task automatic t_scan;
		int seq[4] = '{3, 3, 7, 3};
		for (int i = 0; i < 3; i++) apb(1'b1, 12'h008, 32'(seq[i]));
		far_u.select(1'b1);
		apb(1'b1, 12'h000, 32'h0000_0001);
		// route lags the run state by one edge, so wait one more
		repeat (3) @(posedge pclk);
		chk("mux", 32'(mux), 32'(seq[0]));
		chk("route", 32'(route), 32'h0000_0004);
		for (int i = 1; i < 4; i++) begin
			far_u.convert(2);
			chk("mux", 32'(mux), 32'(seq[i]));
		end
		apb(1'b1, 12'h000, 32'h0000_0007);
		repeat (2) @(posedge pclk);
		chk("route", 32'(route), 32'h0000_0002);
		chk("shunt", 32'(shunt), 32'h0000_0001);
		far_u.select(1'b0);
		repeat (3) @(posedge pclk);
		chk("route", 32'(route), 32'h0000_0001);
		apb(1'b1, 12'h000, 32'h0000_0000);
	endtask
	// unmapped write is refused; bad channel sets the error bit
	task automatic t_refuse;
		apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
		chk("err", 32'(err), 32'h0000_0001);
		apb(1'b1, 12'h008, 32'h0000_0018);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("status err", 32'(rd[25]), 32'h0000_0001);
	endtask
	// clear, reload, step by trigger register, wrap, idle trigger ignored
	task automatic t_list;
		apb(1'b1, 12'h000, 32'h0000_0008);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("count", 32'(rd[23:14]), 32'h0000_0000);
		chk("status err", 32'(rd[25]), 32'h0000_0000);
		apb(1'b1, 12'h008, 32'h0000_0009);
		apb(1'b1, 12'h008, 32'h0000_0002);
		apb(1'b1, 12'h000, 32'h0000_0001);
		apb(1'b0, 12'h000, 32'h0000_0000);
		chk("ctrl rd", rd, 32'h0000_0001);
		chk("mux", 32'(mux), 32'h0000_0009);
		apb(1'b1, 12'h00C, 32'h0000_0000);
		@(posedge pclk);
		chk("mux", 32'(mux), 32'h0000_0002);
		apb(1'b1, 12'h00C, 32'h0000_0000);
		@(posedge pclk);
		chk("mux", 32'(mux), 32'h0000_0009);
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk("status", rd, 32'h0100_8009);
		apb(1'b0, 12'h054, 32'h0000_0000);
		chk("ofs5 rd", rd, 32'h0000_0FFF);
		apb(1'b1, 12'h000, 32'h0000_0000);
		far_u.convert(1);
		chk("mux idle", 32'(mux), 32'h0000_0009);
	endtask

	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	initial begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		test_done;
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_codes;
		t_scan;
		t_refuse;
		t_list;
		test_done;
	end
endmodule
`default_nettype wire
